// file: rtl/cmo_ctrl.sv
// Purpose: Control and status register for comparator one, with pin overrides.
// Assumes: APB slave, 32-bit data, one clock, asynchronous active-low reset.
// Notes:   Status and mask words sit behind the control word at local offsets.
// Function
// [RULE_01] Output path passes result when polarity bit is one, inverted when zero.
// [RULE_02] Enabled comparator with pin input selected forces that pin analog input.
// [RULE_03] Override never alters the stored analog-select value.
// [RULE_04] Comparator off returns pins to own direction and analog-select.
// [RULE_05] Wake-on-change bit gates the wake flag; zero means enabled.
// [RULE_06] Result bit is read-only; other control bits read and write.
// [RULE_07] Wake flag sets on change after a control read when wake enabled.
// [RULE_08] Reset loads all ones, placing comparator input pins in analog mode.
// [RULE_09] Result is low when positive input is below negative, else high.
module cmo_ctrl
  import cmo_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        cmp_raw,
  input  wire logic [1:0]  pin_direction,
  input  wire logic [1:0]  analog_pin_select,
  output logic [1:0]       pin_direction_eff,
  output logic [1:0]       analog_pin_select_eff,
  output logic             cmp_pin_out,
  output logic             cmp_pin_oe,
  output logic             timer_clk_from_cmp,
  output logic             cmp_power_on,
  output logic             neg_input_sel,
  output logic             pos_input_sel,
  output logic             cmp_wake_flag,
  output logic             irq
);

  typedef struct packed {
    logic [6:0] ctrl;
    logic       armed;
    logic       wake;
    logic       mask;
    logic       outp;
    logic [1:0] dir_eff;
    logic [1:0] ans_eff;
    logic [31:0] rdata;
  } cmo_ctrl_st_t;

  cmo_ctrl_st_t st_ff;
  cmo_ctrl_st_t nxt_st;
  cmo_sync_if   sync_bus ();

  logic       acc;
  logic       wr;
  logic       rd;
  logic       hit;
  logic       res;
  logic [7:0] ctrl_word;

  cmo_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .raw_in  (cmp_raw),
    .out     (sync_bus)
  );

  // Apply polarity to a raw result.
  function automatic logic cmo_pol(input logic r, input logic pol);
    return pol ? r : ~r;
  endfunction

  function automatic logic cmo_decode(input logic [11:0] a);
    return (a == CMO_OFS_CTRL) || (a == CMO_OFS_STATUS) || (a == CMO_OFS_MASK);
  endfunction

  assign res       = sync_bus.level; // RULE_09
  assign ctrl_word = {res, st_ff.ctrl};
  assign acc       = psel && penable;
  assign hit       = cmo_decode(paddr);
  assign wr        = acc && pwrite && hit;
  assign rd        = acc && !pwrite && hit;

  always_comb
  begin
    nxt_st = st_ff;
    if (wr && paddr == CMO_OFS_CTRL)
      nxt_st.ctrl = pwdata[6:0] & CMO_CTRL_WMASK[6:0]; // RULE_06
    if (wr && paddr == CMO_OFS_MASK)
      nxt_st.mask = pwdata[0];
    // A control read arms the change detector that sets the wake flag.
    if (rd && paddr == CMO_OFS_CTRL)
      nxt_st.armed = 1'b1; // RULE_07
    if (wr && paddr == CMO_OFS_STATUS && pwdata[0])
      nxt_st.wake = 1'b0;
    // Setting after clearing lets a same-cycle event win.
    if (st_ff.armed && !st_ff.ctrl[CMO_BIT_WAKE] && sync_bus.changed)
      nxt_st.wake = 1'b1; // RULE_05 RULE_07
    nxt_st.outp = cmo_pol(res, st_ff.ctrl[CMO_BIT_POL]); // RULE_01
    // Only a pin that the comparator really uses is taken over; the other stays with software.
    for (int i = 0; i < 2; i++)
    begin
      logic sel;
      sel = (i == CMO_PIN_INP) ? st_ff.ctrl[CMO_BIT_POS_SEL]
                               : (st_ff.ctrl[CMO_BIT_NEG_SEL] || !st_ff.ctrl[CMO_BIT_POS_SEL]);
      if (st_ff.ctrl[CMO_BIT_ON] && sel)
      begin
        nxt_st.dir_eff[i] = 1'b1; // RULE_02
        nxt_st.ans_eff[i] = 1'b1; // RULE_02 RULE_03
      end
      else
      begin
        nxt_st.dir_eff[i] = pin_direction[i]; // RULE_04
        nxt_st.ans_eff[i] = analog_pin_select[i]; // RULE_04
      end
    end
    // Read data is registered in the setup cycle, so it stands through the access phase.
    nxt_st.rdata = 32'h0;
    if (psel && !penable && !pwrite)
    begin
      case (paddr)
        CMO_OFS_CTRL:   nxt_st.rdata = {24'h0, ctrl_word};
        CMO_OFS_STATUS: nxt_st.rdata = {31'h0, st_ff.wake};
        CMO_OFS_MASK:   nxt_st.rdata = {31'h0, st_ff.mask};
        default:        nxt_st.rdata = 32'h0;
      endcase
    end
    else
      nxt_st.rdata = st_ff.rdata;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff         <= '0;
      st_ff.ctrl    <= CMO_CTRL_RST[6:0]; // RULE_08
      st_ff.wake    <= CMO_STAT_RST[0];
      st_ff.mask    <= CMO_MASK_RST[0];
      st_ff.outp    <= 1'b1;
      st_ff.dir_eff <= 2'h3;
      st_ff.ans_eff <= 2'h3;
    end
    else
      st_ff <= nxt_st;
  end

  assign pready                = 1'b1;
  assign pslverr               = acc && !hit;
  assign prdata                = st_ff.rdata;
  assign pin_direction_eff     = st_ff.dir_eff;
  assign analog_pin_select_eff = st_ff.ans_eff;
  assign cmp_pin_out           = st_ff.outp; // RULE_01
  assign cmp_pin_oe            = !st_ff.ctrl[CMO_BIT_PIN_DIS];
  assign timer_clk_from_cmp    = !st_ff.ctrl[CMO_BIT_TMR_SEL];
  assign cmp_power_on          = st_ff.ctrl[CMO_BIT_ON];
  assign neg_input_sel         = st_ff.ctrl[CMO_BIT_NEG_SEL];
  assign pos_input_sel         = st_ff.ctrl[CMO_BIT_POS_SEL];
  assign cmp_wake_flag         = st_ff.wake;
  assign irq                   = st_ff.wake && st_ff.mask;

  a_pol_output: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
    1'b1 |=> cmp_pin_out == ($past(st_ff.ctrl[CMO_BIT_POL]) ? $past(res) : !$past(res)))
    else $error("output polarity wrong");

  a_override_pin: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
    (cmp_power_on && pos_input_sel) |=> analog_pin_select_eff[CMO_PIN_INP])
    else $error("positive pin not forced analog");

  a_revert_pin: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
    !cmp_power_on |=> analog_pin_select_eff == $past(analog_pin_select)
                      && pin_direction_eff == $past(pin_direction))
    else $error("pins not reverted");

  sequence s_armed_change;
    st_ff.armed && !st_ff.ctrl[CMO_BIT_WAKE] && sync_bus.changed;
  endsequence

  a_wake_set: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
    s_armed_change |=> cmp_wake_flag)
    else $error("wake flag not set");

  a_wake_gate: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
    (!cmp_wake_flag && st_ff.ctrl[CMO_BIT_WAKE]) |=> !cmp_wake_flag)
    else $error("wake flag set while disabled");

  a_result_ro: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
    (rd && paddr == CMO_OFS_CTRL) ##1 1'b1 |-> prdata[7] == $past(res, 2))
    else $error("result bit not live");

  a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
    (wr && paddr == CMO_OFS_CTRL) |=> st_ff.ctrl == $past(pwdata[6:0]))
    else $error("control write lost");

  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    irq == (cmp_wake_flag && st_ff.mask))
    else $error("irq mismatch");

  // Register side checks: what software may change, and what it reads back; then pin override and synchroniser checks.
  sequence s_ctrl_read_setup;
    psel && !penable && !pwrite && paddr == CMO_OFS_CTRL;
  endsequence

  sequence s_status_read_setup;
    psel && !penable && !pwrite && paddr == CMO_OFS_STATUS;
  endsequence

  sequence s_unmapped_read_setup;
    psel && !penable && !pwrite && !hit;
  endsequence

  sequence s_status_clear;
    wr && paddr == CMO_OFS_STATUS && pwdata[0]
      && !(st_ff.armed && !st_ff.ctrl[CMO_BIT_WAKE] && sync_bus.changed);
  endsequence

  a_read_ctrl: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
    s_ctrl_read_setup
    |=> prdata == {24'h0, $past(ctrl_word)})
    else $error("control read data wrong");

  a_read_status: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
    s_status_read_setup
    |=> prdata == {31'h0, $past(cmp_wake_flag)})
    else $error("status read data wrong");

  a_read_unmapped: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
    s_unmapped_read_setup
    |=> prdata == 32'h0)
    else $error("unmapped read not zero");

  a_read_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(psel && !penable && !pwrite)
    |=> $stable(prdata))
    else $error("read data moved between reads");

  a_ctrl_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
    !(wr && paddr == CMO_OFS_CTRL)
    |=> $stable(st_ff.ctrl))
    else $error("control bits changed without a write");

  a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == CMO_OFS_MASK)
    |=> st_ff.mask == $past(pwdata[0]))
    else $error("mask write lost");

  a_mask_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr && paddr == CMO_OFS_MASK)
    |=> $stable(st_ff.mask))
    else $error("mask changed without a write");

  a_wake_clear: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
    s_status_clear
    |=> !cmp_wake_flag)
    else $error("wake flag not cleared");

  a_wake_sticky: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
    (cmp_wake_flag && !(wr && paddr == CMO_OFS_STATUS && pwdata[0]))
    |=> cmp_wake_flag)
    else $error("wake flag dropped on its own");

  a_wake_cause: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
    $rose(cmp_wake_flag)
    |-> $past(st_ff.armed && !st_ff.ctrl[CMO_BIT_WAKE] && sync_bus.changed))
    else $error("wake flag set without a cause");

  a_wake_idle: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
    (!cmp_wake_flag && !st_ff.armed)
    |=> !cmp_wake_flag)
    else $error("wake flag set before a control read");

  a_arm_cause: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
    $rose(st_ff.armed)
    |-> $past(rd && paddr == CMO_OFS_CTRL))
    else $error("armed without a control read");

  a_neg_override: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
    (cmp_power_on && (neg_input_sel || !pos_input_sel))
    |=> pin_direction_eff[CMO_PIN_INN] && analog_pin_select_eff[CMO_PIN_INN])
    else $error("negative pin not forced analog");

  a_pos_dir_forced: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
    (cmp_power_on && pos_input_sel)
    |=> pin_direction_eff[CMO_PIN_INP])
    else $error("positive pin not forced to input");

  a_pos_unselected: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
    (cmp_power_on && !pos_input_sel)
    |=> analog_pin_select_eff[CMO_PIN_INP] == $past(analog_pin_select[CMO_PIN_INP])
        && pin_direction_eff[CMO_PIN_INP] == $past(pin_direction[CMO_PIN_INP]))
    else $error("unselected positive pin overridden");

  a_sync_change: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09
    sync_bus.changed
    |-> res == $past(cmp_raw, 4))
    else $error("result does not follow the comparator");

  a_sync_quiet: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09
    !sync_bus.changed
    |-> $stable(res))
    else $error("result moved without a change");

endmodule // cmo_ctrl

// file: rtl/cmo_pkg.sv
// Purpose: Constants for the comparator one control block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Register offsets other than the control word are local choices.
package cmo_pkg;

  localparam logic [11:0] CMO_OFS_CTRL   = 12'h000;
  localparam logic [11:0] CMO_OFS_STATUS = 12'h004;
  localparam logic [11:0] CMO_OFS_MASK   = 12'h008;

  localparam int CMO_BIT_RESULT  = 7;
  localparam int CMO_BIT_PIN_DIS = 6;
  localparam int CMO_BIT_POL     = 5;
  localparam int CMO_BIT_TMR_SEL = 4;
  localparam int CMO_BIT_ON      = 3;
  localparam int CMO_BIT_NEG_SEL = 2;
  localparam int CMO_BIT_POS_SEL = 1;
  localparam int CMO_BIT_WAKE    = 0;

  localparam logic [7:0] CMO_CTRL_RST = 8'hff;
  localparam logic [7:0] CMO_CTRL_WMASK = 8'h7f;
  localparam logic [0:0] CMO_STAT_RST = 1'h0;
  localparam logic [0:0] CMO_MASK_RST = 1'h0;

  // Pin index of the two comparator inputs in the pin override vector.
  localparam int CMO_PIN_INP = 0;
  localparam int CMO_PIN_INN = 1;

endpackage : cmo_pkg

// file: rtl/cmo_sync.sv
// Purpose: Synchronise the raw analog comparator decision into pclk.
// Assumes: Raw input is asynchronous to pclk.
// Notes:   A change counts once the second and third stages agree.
module cmo_sync
  import cmo_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic raw_in,
  cmo_sync_if.src   out
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic chg;
  } cmo_sync_st_t;

  cmo_sync_st_t st_ff;
  cmo_sync_st_t nxt_st;

  always_comb
  begin
    nxt_st     = st_ff;
    nxt_st.s1  = raw_in;
    nxt_st.s2  = st_ff.s1;
    nxt_st.s3  = st_ff.s2;
    nxt_st.chg = 1'b0;
    if ((st_ff.s2 == st_ff.s3) && (st_ff.s3 != st_ff.lvl))
    begin
      nxt_st.lvl = st_ff.s3;
      nxt_st.chg = 1'b1;
    end
  end

  // Reset to one so the result matches the all-ones control word at reset.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_ff <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, lvl: 1'b1, chg: 1'b0};
    else
      st_ff <= nxt_st;
  end

  assign out.level   = st_ff.lvl;
  assign out.changed = st_ff.chg;

endmodule // cmo_sync

// file: rtl/cmo_sync_if.sv
// Purpose: Carries the filtered comparator level between the two modules.
// Assumes: Single clock domain.
// Notes:   The filter drives, the control block consumes.
interface cmo_sync_if;
  logic level;
  logic changed;
  modport src (output level, output changed);
  modport dst (input level, input changed);
endinterface : cmo_sync_if

// file: sim/cmo_analog_model.sv
// Purpose: Model of the comparator core and its two input pins.
// Assumes: Pin voltages are given as unsigned 8-bit levels.
// Notes:   FIXED_REF is an arbitrary scaled level.
module cmo_analog_model #(parameter logic [7:0] FIXED_REF = 8'h30) (
  input  wire logic [7:0] vin_pos_pin,
  input  wire logic [7:0] vin_neg_pin,
  input  wire logic       neg_input_sel,
  input  wire logic       pos_input_sel,
  output logic            cmp_raw
);
  timeunit 1ns;
  timeprecision 1ps;
  // A tie reads high, since only a lower positive input gives a low result.
  assign cmp_raw = ((pos_input_sel ? vin_pos_pin : vin_neg_pin) >=
                    (neg_input_sel ? vin_neg_pin : FIXED_REF));
endmodule // cmo_analog_model

// file: sim/comparator_one_control_test.sv
// Purpose: Self-checking bench for the comparator one control block.
// Assumes: Zero-wait APB slave; comparator levels come from the analog model.
// Notes:   Eight idle cycles cover the input synchroniser and the flag register.
`define CHK(n, x, g) begin cmp_count++; if ((g) !== (x)) begin n_fail++; \
  $display("[FAIL] %s exp %h got %h", n, x, g); end end
module comparator_one_control_test
  import cmo_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, cmp_raw, cmp_pin_out;
  logic        cmp_pin_oe, timer_clk_from_cmp, cmp_power_on, neg_input_sel, pos_input_sel;
  logic        cmp_wake_flag, irq, err_seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  pin_direction, analog_pin_select, pin_direction_eff, analog_pin_select_eff;
  logic [7:0]  vin_pos_pin, vin_neg_pin;
  logic [3:0]  pins;
  logic [4:0]  outs;
  int          n_fail = 0;
  int          cmp_count = 0;
  cmo_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .cmp_raw, .pin_direction, .analog_pin_select, .pin_direction_eff,
    .analog_pin_select_eff, .cmp_pin_out, .cmp_pin_oe, .timer_clk_from_cmp, .cmp_power_on,
    .neg_input_sel, .pos_input_sel, .cmp_wake_flag, .irq);
  cmo_analog_model ana (.vin_pos_pin, .vin_neg_pin, .neg_input_sel, .pos_input_sel,
    .cmp_raw);
  assign pins = {pin_direction_eff, analog_pin_select_eff};
  assign outs = {cmp_pin_oe, timer_clk_from_cmp, cmp_power_on, neg_input_sel, pos_input_sel};
  initial forever #2 pclk = ~pclk;

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Two idle edges after each access let registered outputs settle before checks.
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] x, input string nm);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (n = 0; pready !== 1'b1 && n < 16; n++)
      @(posedge pclk);
    if (n == 16)
      n_fail++;
    if (n == 16)
      stop_test();
    err_seen = pslverr;
    if (!w)
      `CHK(nm, x, prdata)
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  task automatic t_reset();
    acc(1'b0, CMO_OFS_CTRL, 32'h0, 32'h0000_00ff, "ctrl_rst");
    `CHK("pins_rst", 4'b1111, pins)
    `CHK("outs_rst", 5'b00111, outs)
    `CHK("no_err", 1'b0, err_seen)
    acc(1'b0, CMO_OFS_STATUS, 32'h0, 32'h0, "stat_rst");
  endtask

  task automatic t_regs();
    acc(1'b1, CMO_OFS_CTRL, 32'h8, 32'h0, "");
    acc(1'b0, CMO_OFS_CTRL, 32'h0, 32'h88, "ctrl_rw");
    `CHK("outs", 5'b11100, outs)
    `CHK("neg_ovr", 4'b1011, pins)
    acc(1'b0, 12'h00c, 32'h0, 32'h0, "unmapped");
    `CHK("rd_err", 1'b1, err_seen)
    acc(1'b1, 12'h00c, 32'h7f, 32'h0, "");
    `CHK("wr_err", 1'b1, err_seen)
    acc(1'b0, CMO_OFS_CTRL, 32'h0, 32'h88, "ctrl_kept");
  endtask

  task automatic t_polarity();
    acc(1'b1, CMO_OFS_CTRL, 32'h2e, 32'h0, "");
    `CHK("pol_keep", 1'b1, cmp_pin_out)
    `CHK("both_ovr", 4'b1111, pins)
    acc(1'b1, CMO_OFS_CTRL, 32'h0e, 32'h0, "");
    `CHK("pol_inv", 1'b0, cmp_pin_out)
    vin_pos_pin <= 8'h10;
    repeat (8) @(posedge pclk);
    `CHK("pol_inv_lo", 1'b1, cmp_pin_out)
    acc(1'b0, CMO_OFS_CTRL, 32'h0, 32'h0e, "res_lo");
    acc(1'b1, CMO_OFS_CTRL, 32'h06, 32'h0, "");
    `CHK("pins_off", 4'b1001, pins)
  endtask

  task automatic t_wake();
    // A fresh reset drops the arming left by earlier control reads.
    vin_pos_pin <= 8'h80;
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    acc(1'b1, CMO_OFS_MASK, 32'h1, 32'h0, "");
    acc(1'b1, CMO_OFS_CTRL, 32'h2e, 32'h0, "");
    vin_pos_pin <= 8'h10;
    repeat (8) @(posedge pclk);
    `CHK("unarmed", 1'b0, cmp_wake_flag)
    acc(1'b0, CMO_OFS_CTRL, 32'h0, 32'h2e, "arm");
    vin_pos_pin <= 8'h80;
    repeat (8) @(posedge pclk);
    `CHK("wake_irq", 2'b11, {cmp_wake_flag, irq})
    acc(1'b0, CMO_OFS_STATUS, 32'h0, 32'h1, "status");
    acc(1'b1, CMO_OFS_STATUS, 32'h1, 32'h0, "");
    acc(1'b1, CMO_OFS_MASK, 32'h0, 32'h0, "");
    acc(1'b1, CMO_OFS_CTRL, 32'h2f, 32'h0, "");
    `CHK("cleared", 2'b00, {cmp_wake_flag, irq})
    vin_pos_pin <= 8'h10;
    repeat (8) @(posedge pclk);
    `CHK("wake_off", 1'b0, cmp_wake_flag)
    acc(1'b1, CMO_OFS_CTRL, 32'h2e, 32'h0, "");
    vin_pos_pin <= 8'h80;
    repeat (8) @(posedge pclk);
    `CHK("masked", 2'b10, {cmp_wake_flag, irq})
  endtask

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    pin_direction = 2'b10;
    analog_pin_select = 2'b01;
    vin_pos_pin = 8'h80;
    vin_neg_pin = 8'h40;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_polarity();
    t_wake();
    stop_test();
  end
endmodule // comparator_one_control_test
